// File: verilog/pemr_cfg.svh
// Offsets, field positions, reset values and widths of the MMD register bank
`ifndef PEMR_CFG_SVH
`define PEMR_CFG_SVH

// Bus and register widths
`define PEMR_ADDR_W            12
`define PEMR_DATA_W            32
`define PEMR_REG_W             16

// MMD device numbers and register indexes
`define PEMR_MMD_PCS           5'h03
`define PEMR_MMD_AUTONEG       5'h07
`define PEMR_IDX_WAKE_ERR      6'h16
`define PEMR_IDX_PRESENT_LOW   6'h05
`define PEMR_IDX_PRESENT_HIGH  6'h06
`define PEMR_IDX_LOCAL_ADV     6'h3C
`define PEMR_IDX_PARTNER_ADV   6'h3D

// Word index = device * 64 + register index; byte address = 4 * index
`define PEMR_WIDX_W            10
`define PEMR_WIDX_WAKE_ERR     10'h0D6
`define PEMR_WIDX_PRESENT_LOW  10'h1C5
`define PEMR_WIDX_PRESENT_HIGH 10'h1C6
`define PEMR_WIDX_LOCAL_ADV    10'h1FC
`define PEMR_WIDX_PARTNER_ADV  10'h1FD

// Fixed devices-present words
`define PEMR_PRESENT_LOW_VAL   16'h0088
`define PEMR_PRESENT_HIGH_VAL  16'h4000

// Field positions
`define PEMR_BIT_AN_PRESENT    7
`define PEMR_BIT_PCS_PRESENT   3
`define PEMR_BIT_VEND1_PRESENT 14
`define PEMR_BIT_TX100_EEE     1
`define PEMR_PARTNER_LSB       1
`define PEMR_PARTNER_MSB       6

// Reset values and wake error counter limit
`define PEMR_WAKE_ERR_RST      16'h0000
`define PEMR_WAKE_ERR_MAX      16'hFFFF
`define PEMR_PARTNER_RST       6'h00

// Avalon response codes
`define PEMR_RESP_OKAY         2'h0
`define PEMR_RESP_SLVERR       2'h2

`endif

// File: verilog/pemr_pkg.sv
// Types shared by the MMD register bank
`default_nettype none

package pemr_pkg;

  // Bus slave handshake states, one-hot
  typedef enum logic [1:0] {
    PEMR_ST_IDLE = 2'b01,
    PEMR_ST_ACK  = 2'b10
  } pemr_state_e;

  // Register selected by a bus address
  typedef enum logic [2:0] {
    PEMR_SEL_NONE,
    PEMR_SEL_WAKE_ERR,
    PEMR_SEL_PRESENT_LOW,
    PEMR_SEL_PRESENT_HIGH,
    PEMR_SEL_LOCAL_ADV,
    PEMR_SEL_PARTNER_ADV
  } pemr_sel_e;

endpackage

`default_nettype wire

// File: verilog/pemr_regs.sv
// MMD register bank: wake error counter, devices present, EEE advertisement
//
// Function
// - Wake error count register sits at index 22 of MMD device 3.
// - Wake error counter clears on read and is zero after reset.
// - Wake error counter holds at all ones instead of wrapping.
// - First autoneg devices-present word reads bit 7 as one.
// - First autoneg devices-present word reads bit 3 as one.
// - First word bits 6,5,4,2,1,0 read zero; bits 15:8 reserved.
// - Second devices-present word at 7.6 reads bit 14 as one.
// - Second word bits 15 and 13 read zero; bits 12:0 reserved.
// - Local EEE advertisement at 7.60; bit 1 advertises 100BASE-TX EEE.
// - Local advertisement bit 1 is read/write; other bits read-only.
// - Local advertisement bit at 7.60 resets to the EEE enable setting; the local_tx100_eee_adv port resets to zero.
// - Partner EEE advertisement at 7.61, all bits read-only.
// - Partner bit 1 shows partner 100BASE-TX EEE; resets to zero.
// - Partner bits 6:2 show other partner modes; reset to zero.
`include "pemr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module pemr_regs (
  input  wire logic                           clock,
  input  wire logic                           reset,
  input  wire logic [`PEMR_ADDR_W-1:0]        avs_address,
  input  wire logic                           avs_read,
  input  wire logic                           avs_write,
  input  wire logic [`PEMR_DATA_W-1:0]        avs_writedata,
  input  wire logic [3:0]                     avs_byteenable,
  output logic      [`PEMR_DATA_W-1:0]        avs_readdata,
  output logic                                avs_waitrequest,
  output logic      [1:0]                     avs_response,
  input  wire logic                           energy_efficient_link_enable,
  input  wire logic                           wake_error_event,
  input  wire logic                           partner_adv_load,
  input  wire logic [`PEMR_PARTNER_MSB:`PEMR_PARTNER_LSB] partner_adv_bits,
  input  wire logic                           link_down,
  output logic                                local_tx100_eee_adv
);

  // Address decode, shared by read and write paths
  function automatic pemr_pkg::pemr_sel_e decode_sel(
    input logic [`PEMR_ADDR_W-1:0] addr
  );
    logic [`PEMR_WIDX_W-1:0] widx;
    widx = addr[`PEMR_ADDR_W-1:2];
    case (widx)
      `PEMR_WIDX_WAKE_ERR:     decode_sel = pemr_pkg::PEMR_SEL_WAKE_ERR;
      `PEMR_WIDX_PRESENT_LOW:  decode_sel = pemr_pkg::PEMR_SEL_PRESENT_LOW;
      `PEMR_WIDX_PRESENT_HIGH: decode_sel = pemr_pkg::PEMR_SEL_PRESENT_HIGH;
      `PEMR_WIDX_LOCAL_ADV:    decode_sel = pemr_pkg::PEMR_SEL_LOCAL_ADV;
      `PEMR_WIDX_PARTNER_ADV:  decode_sel = pemr_pkg::PEMR_SEL_PARTNER_ADV;
      default:                 decode_sel = pemr_pkg::PEMR_SEL_NONE;
    endcase
  endfunction

  pemr_pkg::pemr_state_e                  state_r;
  pemr_pkg::pemr_state_e                  state_nxt;
  pemr_pkg::pemr_sel_e                    sel;
  logic                                   accept;
  logic                                   rd_take;
  logic                                   wr_take;
  logic [`PEMR_REG_W-1:0]                 wake_err_r;
  logic [`PEMR_REG_W-1:0]                 wake_err_nxt;
  logic                                   local_adv_r;
  logic [`PEMR_PARTNER_MSB:`PEMR_PARTNER_LSB] partner_r;
  logic [`PEMR_REG_W-1:0]                 rd_word;
  logic [`PEMR_DATA_W-1:0]                readdata_r;
  logic                                   waitreq_r;
  logic [1:0]                             response_r;

  assign sel     = decode_sel(avs_address);
  assign accept  = (state_r == pemr_pkg::PEMR_ST_IDLE) &&
                   (avs_read || avs_write);
  assign rd_take = accept && avs_read;
  assign wr_take = accept && avs_write && !avs_read;

  // Handshake state
  always_comb begin
    case (state_r)
      pemr_pkg::PEMR_ST_IDLE: begin
        state_nxt = accept ? pemr_pkg::PEMR_ST_ACK : pemr_pkg::PEMR_ST_IDLE;
      end
      pemr_pkg::PEMR_ST_ACK: begin
        state_nxt = pemr_pkg::PEMR_ST_IDLE;
      end
      default: begin
        state_nxt = pemr_pkg::PEMR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= pemr_pkg::PEMR_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Waitrequest drops for the single answer cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      waitreq_r <= 1'b1;
    end else begin
      waitreq_r <= !accept;
    end
  end

  // Read word assembly
  always_comb begin
    rd_word = '0;
    case (sel)
      pemr_pkg::PEMR_SEL_WAKE_ERR: begin
        rd_word = wake_err_r;
      end
      pemr_pkg::PEMR_SEL_PRESENT_LOW: begin
        rd_word = `PEMR_PRESENT_LOW_VAL;
      end
      pemr_pkg::PEMR_SEL_PRESENT_HIGH: begin
        rd_word = `PEMR_PRESENT_HIGH_VAL;
      end
      pemr_pkg::PEMR_SEL_LOCAL_ADV: begin
        rd_word[`PEMR_BIT_TX100_EEE] = local_adv_r;
      end
      pemr_pkg::PEMR_SEL_PARTNER_ADV: begin
        rd_word[`PEMR_PARTNER_MSB:`PEMR_PARTNER_LSB] = partner_r;
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  // Read data and response captured at acceptance
  always_ff @(posedge clock) begin
    if (reset) begin
      readdata_r <= '0;
      response_r <= `PEMR_RESP_OKAY;
    end else if (accept) begin
      readdata_r <= rd_take ? {16'h0000, rd_word} : '0;
      response_r <= (sel == pemr_pkg::PEMR_SEL_NONE) ?
                    `PEMR_RESP_SLVERR : `PEMR_RESP_OKAY;
    end
  end

  // Wake error counter: saturating, cleared by read, event beats clear
  always_comb begin
    wake_err_nxt = wake_err_r;
    if (rd_take && sel == pemr_pkg::PEMR_SEL_WAKE_ERR) begin
      wake_err_nxt = `PEMR_WAKE_ERR_RST;
    end
    if (wake_error_event) begin
      if (wake_err_nxt != `PEMR_WAKE_ERR_MAX) begin
        wake_err_nxt = wake_err_nxt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wake_err_r <= `PEMR_WAKE_ERR_RST;
    end else begin
      wake_err_r <= wake_err_nxt;
    end
  end

  // Local 100BASE-TX advertisement bit
  always_ff @(posedge clock) begin
    if (reset) begin
      local_adv_r <= energy_efficient_link_enable;
    end else if (wr_take && sel == pemr_pkg::PEMR_SEL_LOCAL_ADV &&
                 avs_byteenable[0]) begin
      local_adv_r <= avs_writedata[`PEMR_BIT_TX100_EEE];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      local_tx100_eee_adv <= 1'b0;
    end else begin
      local_tx100_eee_adv <= local_adv_r;
    end
  end

  // Partner advertisement bits, loaded from autoneg, cleared on link loss
  genvar gi;
  generate
    for (gi = `PEMR_PARTNER_LSB; gi <= `PEMR_PARTNER_MSB; gi = gi + 1) begin : g_lp
      always_ff @(posedge clock) begin
        if (reset || link_down) begin
          partner_r[gi] <= 1'b0;
        end else if (partner_adv_load) begin
          partner_r[gi] <= partner_adv_bits[gi];
        end
      end
    end
  endgenerate

  assign avs_readdata    = readdata_r;
  assign avs_waitrequest = waitreq_r;
  assign avs_response    = response_r;

endmodule

`default_nettype wire

// File: tb/pemr_regs_monitor.sv
// Checker for the MMD register bank bus answers
`timescale 1ns/1ps
`default_nettype none
module pemr_regs_chk (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  input wire logic        partner_adv_load,
  input wire logic        link_down,
  input wire logic        local_tx100_eee_adv
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire logic rg = avs_read && avs_waitrequest;
  AST_ANSWER: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1
    avs_waitrequest) else $error("bad wait");
  AST_HOLD: assert property (
    !avs_read && !avs_write && avs_waitrequest |=> $stable(avs_readdata))
    else $error("data moved");
  AST_PRES_LOW: assert property (
    rg && avs_address == 12'h714 |=> avs_readdata == 32'h88
    && avs_response == 2'h0) else $error("bad low word");
  AST_PRES_HIGH: assert property (
    rg && avs_address == 12'h718 |=> avs_readdata == 32'h4000)
    else $error("bad high word");
  AST_LOCAL: assert property (
    rg && avs_address == 12'h7F0 |=> avs_readdata[31:2] == 30'h0 &&
    !avs_readdata[0] && avs_readdata[1] == local_tx100_eee_adv)
    else $error("bad advert");
  AST_PARTNER: assert property (
    rg && avs_address == 12'h7F4 |=> avs_readdata[31:7] == 25'h0 &&
    !avs_readdata[0]) else $error("bad partner");
  AST_LINK_CLR: assert property (
    rg && avs_address == 12'h7F4 && $past(link_down) && !partner_adv_load
    |=> avs_readdata[6:1] == 6'h00) else $error("partner not cleared");
  AST_UNMAPPED: assert property (
    rg && avs_address == 12'h000 |=> avs_readdata == 32'h0 &&
    avs_response == 2'h2) else $error("bad unmapped");
  cover property (rg && avs_address == 12'h358);
  cover property (avs_write && avs_waitrequest);
  cover property (link_down && rg);
endmodule
`default_nettype wire

// File: tb/pemr_regs_test.sv
// Directed bench for the MMD register bank
`timescale 1ns/1ps
`default_nettype none
module pemr_regs_test;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [11:0] addr = 12'h000;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        waitreq;
  logic [1:0]  resp;
  logic        een = 1'b1;
  logic        wake = 1'b0;
  logic        pload = 1'b0;
  logic        ldown = 1'b0;
  logic [6:1]  pbits = 6'h00;
  logic        adv;
  int          n_mismatch = 0;
  int          n_checks = 0;
  always #12.5 clock = ~clock;
  pemr_regs pemr_regs_inst (.clock(clock), .reset(reset),
    .avs_address(addr), .avs_read(rd_en), .avs_write(wr_en),
    .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .avs_response(resp),
    .energy_efficient_link_enable(een), .wake_error_event(wake),
    .partner_adv_load(pload), .partner_adv_bits(pbits),
    .link_down(ldown), .local_tx100_eee_adv(adv));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [31:0] e,
                     input logic [1:0] er);
    @(posedge clock);
    rd_en <= !w;
    wr_en <= w;
    addr <= a;
    wdata <= d;
    do @(posedge clock); while (waitreq !== 1'b0);
    if (!w) chk(rdata, e);
    chk({30'h0, resp}, {30'h0, er});
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, e, (a == 12'h000) ? 2'h2 : 2'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0, 2'h0);
  endtask
  task automatic do_reset(input logic en);
    @(posedge clock);
    reset <= 1'b1;
    een <= en;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
  endtask
  task automatic wakes(input int n);
    @(posedge clock);
    wake <= 1'b1;
    repeat (n) @(posedge clock);
    wake <= 1'b0;
  endtask
  initial begin
    repeat (90000) @(posedge clock);
    n_mismatch++;
    print_verdict;
  end
  initial begin
    do_reset(1'b1);
    rd(12'h7F0, 32'h2);
    chk({31'h0, adv}, 32'h1);
    rd(12'h714, 32'h88);
    wr(12'h714, 32'hFFFFFFFF);
    rd(12'h714, 32'h88);
    rd(12'h718, 32'h4000);
    rd(12'h000, 32'h0);
    $display("test present done");
    wr(12'h7F0, 32'h0);
    rd(12'h7F0, 32'h0);
    wr(12'h7F0, 32'hFFFFFFFF);
    rd(12'h7F0, 32'h2);
    $display("test advert done");
    rd(12'h358, 32'h0);
    wakes(5);
    rd(12'h358, 32'h5);
    rd(12'h358, 32'h0);
    wakes(65540);
    rd(12'h358, 32'hFFFF);
    rd(12'h358, 32'h0);
    $display("test counter done");
    @(posedge clock);
    pbits <= 6'h2B;
    pload <= 1'b1;
    @(posedge clock);
    pload <= 1'b0;
    rd(12'h7F4, 32'h56);
    wr(12'h7F4, 32'h0);
    rd(12'h7F4, 32'h56);
    ldown <= 1'b1;
    rd(12'h7F4, 32'h0);
    ldown <= 1'b0;
    $display("test partner done");
    do_reset(1'b0);
    rd(12'h7F0, 32'h0);
    chk({31'h0, adv}, 32'h0);
    rd(12'h358, 32'h0);
    rd(12'h7F4, 32'h0);
    $display("test reset done");
    print_verdict;
  end
endmodule
bind pemr_regs pemr_regs_chk pemr_regs_chk_inst (.clock, .reset,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .avs_response, .partner_adv_load, .link_down, .local_tx100_eee_adv);
`default_nettype wire
